//--- include/css_pkg.sv
// Shared constants for the card-side serial status and timing block
package css_pkg;
  // Serial byte and timing units (one unit is eight link clocks)
  localparam int UNIT_CLOCKS = 8;
  localparam int RESP_MAX_UNITS = 8;
  localparam logic [3:0] RESP_USE_UNITS = 4'h1;
  localparam int POST_STOP_MAX_UNITS = 1;
  // Tokens and fill bytes
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] BUSY_BYTE = 8'h00;
  localparam logic [7:0] STOP_TRAN_TOKEN = 8'hFD;
  // Register selects; only three registers are reachable
  localparam logic [1:0] SEL_OPCOND = 2'h0;
  localparam logic [1:0] SEL_SPECDATA = 2'h1;
  localparam logic [1:0] SEL_IDENT = 2'h2;
  // Positions of the clear-on-read flags
  localparam int NFLAG = 15;
  localparam int F_PARAM = 0;
  localparam int F_ADDR = 1;
  localparam int F_ESEQ = 2;
  localparam int F_CRC = 3;
  localparam int F_ILL = 4;
  localparam int F_ERST = 5;
  localparam int F_OOR = 6;
  localparam int F_EPAR = 7;
  localparam int F_WPV = 8;
  localparam int F_ECC = 9;
  localparam int F_CC = 10;
  localparam int F_ERR = 11;
  localparam int F_SKIP = 12;
  localparam int F_LOCKF = 13;
  localparam int F_OVWR = 14;
  // Flags carried by each response kind
  localparam logic [14:0] M_SHORT = 15'h003F;
  localparam logic [14:0] M_STAT2 = 15'h7FC0;
  localparam logic [14:0] M_TOKEN = 15'h0E40;
  localparam logic [14:0] FLAGS_RST = 15'h0000;
  // What the transmitter is sending in the current byte
  typedef enum logic [2:0] {
    K_FILL, K_SHORT, K_STAT2, K_TOKEN, K_DATA, K_BUSY
  } css_kind_t;
endpackage

//--- hdl/css_card.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Status goes out in three response carriers
// - Error bits clear once the host reads them
// - Idle bit is a level, set until init
// - Misaligned address sets address error bit
// - Oversized argument sets out of range bit
// - Failed command checksum sets checksum error
// - Failed internal correction sets its bit
// - Partial protected erase sets skip bit
// - Discarded erase sequence sets erase reset
// - Read-only field overwrite sets overwrite bit
// - Lock or unlock failure sets bit
// - Only three registers reachable by host
// - Busy-extended response followed by busy bytes
// - Release output one clock after deselect
// - Reselected while busy drives low again
// - Stop ends read data at the next falling link clock edge
// - One undefined byte after stop token
// - Stop token timed like a data block
// - Gaps counted in eight-clock units
// - Short response top bit is zero
// - Busy bytes zero, non-zero means ready
// - Error token low bits mirror status bits
// - Tokens shifted out top bit first

// Small read-data FIFO, ready on the fill side is registered
module css_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] DEPTH = CW'(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          push;
  logic          pop;

  // Handshakes on both sides
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign next_count = count + CW'(push) - CW'(pop);

  // Storage
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Occupancy and registered ready
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      count <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      count <= next_count;
      in_ready <= (next_count != DEPTH);
    end
  end
endmodule

// Card-side serial responder: status flags, busy, stop and read data
module css_card (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Serial link pins
  input  wire logic       link_sclk,
  input  wire logic       link_cs_n,
  input  wire logic       link_mosi,
  output logic            card_serial_output,
  output logic            card_serial_output_oe,
  // Error events from the card core, one-cycle pulses
  input  wire logic       ev_param_err,
  input  wire logic       ev_addr_err,
  input  wire logic       ev_erase_seq,
  input  wire logic       ev_crc_err,
  input  wire logic       ev_illegal,
  input  wire logic       ev_erase_reset,
  input  wire logic       ev_out_of_range,
  input  wire logic       ev_erase_param,
  input  wire logic       ev_wp_violation,
  input  wire logic       ev_ecc_failed,
  input  wire logic       ev_cc_error,
  input  wire logic       ev_general_err,
  input  wire logic       ev_erase_skip,
  input  wire logic       ev_lock_failed,
  input  wire logic       ev_overwrite,
  // Card state levels and pulses
  input  wire logic       reset_cmd,
  input  wire logic       init_done,
  input  wire logic       card_locked,
  input  wire logic       card_busy,
  input  wire logic       multi_write,
  // Response requests, one-cycle pulses
  input  wire logic       send_short,
  input  wire logic       send_status,
  input  wire logic       send_err_token,
  input  wire logic       stop_read,
  // Register access check
  input  wire logic       reg_req,
  input  wire logic [1:0] reg_sel,
  output logic            reg_ok,
  // Read data stream into the FIFO
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_ready,
  // Received bytes and status view
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            idle_state,
  output logic [14:0]     flags
);
  import css_pkg::*;

  logic cs_m, cs_s, cs_d, sclk_m, sclk_s, sclk_d, mosi_m, mosi_s;
  logic cs_fall, sclk_rise, sclk_fall;
  logic [7:0] tx_shift, rx_sh, next_byte;
  logic [2:0] bit_cnt, rx_cnt;
  css_kind_t kind, next_kind;
  logic [14:0] cur_mask, next_mask, ev_vec, clr;
  logic resp_pend, stat2_pend, tok_pend, post_pend, drop, stop_seen;
  logic [3:0] gap;
  logic load_en, done, abort_now, f_valid, f_pop, reg_bad;
  logic [7:0] f_data;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      {cs_m, cs_s, cs_d} <= 3'h7;
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {mosi_m, mosi_s} <= 2'h3;
    end
    else
    begin
      {cs_m, cs_s, cs_d} <= {link_cs_n, cs_m, cs_s};
      {sclk_m, sclk_s, sclk_d} <= {link_sclk, sclk_m, sclk_s};
      {mosi_m, mosi_s} <= {link_mosi, mosi_m};
    end
  end

  // Edges of the sampled link clock and select
  assign cs_fall = cs_d & ~cs_s;
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  assign done = sclk_fall & (bit_cnt == 3'h7);
  assign abort_now = drop & (kind == K_DATA);
  assign load_en = cs_fall | done;
  assign f_pop = (load_en & (next_kind == K_DATA)) | drop;
  assign card_serial_output = tx_shift[7];

  // Read data buffer; the core stalls on rd_ready
  css_fifo #(.W(8), .D(4)) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_data   (rd_data),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // Event vector in flag order
  assign ev_vec = {ev_overwrite, ev_lock_failed, ev_erase_skip,
                   ev_general_err, ev_cc_error, ev_ecc_failed,
                   ev_wp_violation, ev_erase_param, ev_out_of_range,
                   ev_erase_reset, ev_illegal | reg_bad, ev_crc_err,
                   ev_erase_seq, ev_addr_err, ev_param_err};
  // Only flags that were in a finished byte are cleared
  assign clr = done ? cur_mask : FLAGS_RST;

  // Sticky error flags; a new event beats the clear
  for (genvar i = 0; i < NFLAG; i++)
  begin : g_flag
    always_ff @(posedge clock)
    begin
      if (!rstn)
        flags[i] <= FLAGS_RST[i];
      else
        flags[i] <= (flags[i] & ~clr[i]) | ev_vec[i];
    end
  end

  // Idle is a level, not cleared by reading
  always_ff @(posedge clock)
  begin
    if (!rstn)
      idle_state <= 1'b1;
    else if (reset_cmd)
      idle_state <= 1'b1;
    else if (init_done)
      idle_state <= 1'b0;
  end

  // Register selects outside the three reachable ones are illegal
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      reg_ok <= 1'b0;
      reg_bad <= 1'b0;
    end
    else
    begin
      reg_ok <= reg_req & (reg_sel == SEL_OPCOND | reg_sel == SEL_SPECDATA
                | reg_sel == SEL_IDENT);
      reg_bad <= reg_req & (reg_sel > SEL_IDENT);
    end
  end

  // Byte source, highest priority first
  always_comb
  begin
    next_byte = FILL_BYTE;
    next_kind = K_FILL;
    next_mask = FLAGS_RST;
    if (gap != 4'h0 && (resp_pend || tok_pend))
      next_kind = K_FILL;
    else if (resp_pend)
    begin
      next_kind = K_SHORT;
      next_byte = {1'b0, flags[F_PARAM], flags[F_ADDR], flags[F_ESEQ],
                   flags[F_CRC], flags[F_ILL], flags[F_ERST],
                   idle_state};
      next_mask = flags & M_SHORT;
    end
    else if (stat2_pend)
    begin
      next_kind = K_STAT2;
      next_byte = {flags[F_OOR] | flags[F_OVWR], flags[F_EPAR],
                   flags[F_WPV], flags[F_ECC], flags[F_CC], flags[F_ERR],
                   flags[F_SKIP] | flags[F_LOCKF], card_locked};
      next_mask = flags & M_STAT2;
    end
    else if (tok_pend)
    begin
      next_kind = K_TOKEN;
      next_byte = {4'h0, flags[F_OOR], flags[F_ECC], flags[F_CC],
                   flags[F_ERR]};
      next_mask = flags & M_TOKEN;
    end
    else if (post_pend)
      next_kind = K_FILL;
    else if (f_valid && !drop)
    begin
      next_kind = K_DATA;
      next_byte = f_data;
    end
    else if (card_busy)
    begin
      next_kind = K_BUSY;
      next_byte = BUSY_BYTE;
    end
  end

  // Shifter changes on the falling link edge, top bit first
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tx_shift <= FILL_BYTE;
      bit_cnt <= 3'h0;
      kind <= K_FILL;
      cur_mask <= FLAGS_RST;
    end
    else if (load_en)
    begin
      tx_shift <= next_byte;
      bit_cnt <= 3'h0;
      kind <= next_kind;
      cur_mask <= next_mask;
    end
    else if (sclk_fall)
    begin
      // A stop cuts data at once but keeps the byte boundary, so the
      // response still lands on the host's byte grid
      if (abort_now)
      begin
        tx_shift <= FILL_BYTE;
        kind <= K_FILL;
      end
      else
        tx_shift <= {tx_shift[6:0], 1'b1};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Drive only while selected; follows select by one clock
  always_ff @(posedge clock)
  begin
    if (!rstn)
      card_serial_output_oe <= 1'b0;
    else
      card_serial_output_oe <= ~cs_s;
  end

  // Pending responses; a request in the load cycle is kept
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      resp_pend <= 1'b0;
      stat2_pend <= 1'b0;
      tok_pend <= 1'b0;
      post_pend <= 1'b0;
      gap <= 4'h0;
    end
    else
    begin
      resp_pend <= send_short | send_status | stop_read
                   | (resp_pend & ~(load_en & next_kind == K_SHORT));
      stat2_pend <= send_status
                    | (stat2_pend & ~(load_en & next_kind == K_STAT2));
      tok_pend <= send_err_token
                  | (tok_pend & ~(load_en & next_kind == K_TOKEN));
      post_pend <= stop_seen
                   | (post_pend & ~(load_en & next_kind == K_FILL
                      & !resp_pend & !tok_pend));
      if (send_short | send_status | send_err_token | stop_read)
        gap <= RESP_USE_UNITS;
      else if (load_en && gap != 4'h0 && (resp_pend || tok_pend))
        gap <= gap - 4'h1;
    end
  end

  // Stop flushes buffered read data; core must stop pushing
  always_ff @(posedge clock)
  begin
    if (!rstn)
      drop <= 1'b0;
    else if (stop_read)
      drop <= 1'b1;
    else if (!f_valid && kind != K_DATA)
      drop <= 1'b0;
  end

  // Receiver samples on the rising link edge
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rx_sh <= 8'h00;
      rx_cnt <= 3'h0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      stop_seen <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      stop_seen <= 1'b0;
      if (cs_s)
        rx_cnt <= 3'h0;
      else if (sclk_rise)
      begin
        rx_sh <= {rx_sh[6:0], mosi_s};
        rx_cnt <= rx_cnt + 3'h1;
        if (rx_cnt == 3'h7)
        begin
          rx_byte <= {rx_sh[6:0], mosi_s};
          rx_valid <= 1'b1;
          stop_seen <= multi_write
                       & ({rx_sh[6:0], mosi_s} == STOP_TRAN_TOKEN);
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_release_out: assert property ($rose(cs_s) |=> !card_serial_output_oe)
    else $error("output still driven after deselect");
  a_busy_resume: assert property (cs_fall && card_busy && !resp_pend
    && !stat2_pend && !tok_pend && !post_pend && !f_valid
    |=> card_serial_output_oe && !card_serial_output)
    else $error("busy not resumed after reselect");
  a_busy_zero: assert property (kind == K_BUSY && bit_cnt == 3'h0
    |-> tx_shift == BUSY_BYTE)
    else $error("busy byte not zero");
  a_short_msb: assert property (kind == K_SHORT && bit_cnt == 3'h0
    |-> !card_serial_output)
    else $error("short response top bit set");
  a_token_high: assert property (load_en && next_kind == K_TOKEN
    |=> tx_shift[7:4] == 4'h0 && tx_shift[0] == $past(flags[F_ERR]))
    else $error("error token malformed");
  a_set_wins: assert property (ev_vec != FLAGS_RST
    |=> (flags & $past(ev_vec)) == $past(ev_vec))
    else $error("event lost");
  a_clear_read: assert property (done && ev_vec == FLAGS_RST
    |=> (flags & $past(cur_mask)) == FLAGS_RST)
    else $error("read flag not cleared");
  a_idle_level: assert property (reset_cmd ##1 !init_done && !reset_cmd
    |=> idle_state)
    else $error("idle dropped without init");
  a_idle_drop: assert property (init_done && !reset_cmd |=> !idle_state)
    else $error("idle did not drop");
  a_stop_cease: assert property (stop_read && kind == K_DATA && !cs_s
    |-> ##[1:60] kind != K_DATA)
    else $error("read data not stopped");
  a_reg_illegal: assert property (reg_req && reg_sel > SEL_IDENT
    |=> ##1 flags[F_ILL])
    else $error("bad register not flagged");

  c_busy_resume: cover property (cs_fall && card_busy ##1 card_serial_output_oe);
  c_stop_read: cover property (stop_read && kind == K_DATA);
  c_status_sent: cover property (kind == K_STAT2 && done);
  c_token_sent: cover property (kind == K_TOKEN && done);
endmodule

//--- sim/css_host.sv
`timescale 1ns/100ps
// Host controller model: makes the link clock only inside byte transfers
module css_host (
  // Serial link pins
  output logic       sclk,
  output logic       cs_n,
  output logic       mosi,
  input  wire logic  miso,
  input  wire logic  miso_oe,
  // Byte just received, with a short strobe for the bench monitor
  output logic [7:0] rx_data,
  output logic       rx_strobe
);
  // Half period of the 64 ns link clock
  localparam real HALF = 32.0;
  logic line;

  // Card output has a pull-up, so a released line reads high
  assign line = (miso_oe === 1'b1) ? miso : 1'b1;

  // Idle levels at time zero
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
    rx_data = 8'h00;
    rx_strobe = 1'b0;
  end

  // Select the card; clock stands still until a byte is sent
  task automatic select();
    #(HALF) cs_n = 1'b0;
    #(2 * HALF);
  endtask

  // Deselect at any time; the released data line must not hold its value
  task automatic deselect();
    #(HALF) cs_n = 1'b1;
    mosi = ~mosi;
    #(2 * HALF);
  endtask

  // One byte each way, top bit first; data changes while clock is low
  task automatic xfer(input logic [7:0] tx);
    logic [7:0] got;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      #(HALF) sclk = 1'b1;
      got[i] = line;
      #(HALF) sclk = 1'b0;
    end
    rx_data = got;
    rx_strobe = 1'b1;
    #1 rx_strobe = 1'b0;
  endtask
endmodule

//--- sim/card_spi_status_timing_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the card-side serial status block
module card_spi_status_timing_bench;
  import css_pkg::*;
  // Stimulus and observed signals
  logic        clock, rstn, link_sclk, link_cs_n, link_mosi, so, so_oe;
  logic        card_locked, card_busy, multi_write, reg_req, reg_ok;
  logic        rd_valid, rd_ready, rx_valid, idle_state, rx_strobe;
  logic [1:0]  reg_sel, idl;
  logic [3:0]  rq;
  logic [7:0]  rd_data, rx_byte, host_rx, last_rx;
  logic [14:0] ev, flags;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  logic [7:0]  dq[$];
  int          err_count, check_count, seed, oe_lag, oe_max, n;
  // Where each flag shows: short byte high, second status byte low
  localparam logic [15:0] STAT_OF[15] = '{16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'h0400, 16'h0200, 16'h0080, 16'h0040, 16'h0020, 16'h0010,
    16'h0008, 16'h0004, 16'h0002, 16'h0002, 16'h0080};

  css_card dut_u (
    .clock(clock), .rstn(rstn), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .card_serial_output(so), .card_serial_output_oe(so_oe),
    .ev_param_err(ev[0]), .ev_addr_err(ev[1]), .ev_erase_seq(ev[2]),
    .ev_crc_err(ev[3]), .ev_illegal(ev[4]), .ev_erase_reset(ev[5]),
    .ev_out_of_range(ev[6]), .ev_erase_param(ev[7]),
    .ev_wp_violation(ev[8]), .ev_ecc_failed(ev[9]), .ev_cc_error(ev[10]),
    .ev_general_err(ev[11]), .ev_erase_skip(ev[12]),
    .ev_lock_failed(ev[13]), .ev_overwrite(ev[14]),
    .reset_cmd(idl[1]), .init_done(idl[0]), .card_locked(card_locked),
    .card_busy(card_busy), .multi_write(multi_write),
    .send_short(rq[0]), .send_status(rq[1]), .send_err_token(rq[2]),
    .stop_read(rq[3]), .reg_req(reg_req), .reg_sel(reg_sel),
    .reg_ok(reg_ok), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .idle_state(idle_state), .flags(flags)
  );

  css_host host_u (
    .sclk(link_sclk), .cs_n(link_cs_n), .mosi(link_mosi), .miso(so),
    .miso_oe(so_oe), .rx_data(host_rx), .rx_strobe(rx_strobe)
  );

  // 200 MHz system clock
  always #2.5 clock = ~clock;

  // Longest wait, in clocks, for the output enable to follow select
  always @(posedge clock)
  begin
    oe_lag = (link_cs_n === so_oe) ? oe_lag + 1 : 0;
    if (oe_lag > oe_max)
      oe_max = oe_lag;
  end

  // Last byte the card received from the host
  always @(posedge clock)
    if (rx_valid === 1'b1)
      last_rx <= rx_byte;

  // Compare each received byte with the oldest note, masked bits only;
  // the trailing edge of the strobe leaves the byte settled
  always @(negedge rx_strobe)
    if (exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(16'(host_rx & note[15:8]), 16'(note[7:0] & note[15:8]));
    end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Note an expected byte; a zero mask leaves it unchecked
  task automatic want(input logic [7:0] v, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, v});
  endtask

  // Host reads bytes, stalling between them
  task automatic frame(input int k);
    repeat (k)
    begin
      host_u.xfer(FILL_BYTE);
      tick(10);
    end
  endtask

  // One-cycle pulses of events, requests and idle controls
  task automatic pulse(input logic [14:0] e, input logic [3:0] r,
                       input logic [1:0] i = 2'h0);
    ev = e;
    rq = r;
    idl = i;
    tick();
    ev = '0;
    rq = '0;
    idl = '0;
    tick(2);
  endtask

  // Request a response: the byte in flight, then one gap fill byte
  task automatic ask(input logic [3:0] r);
    pulse('0, r);
    want(FILL_BYTE);
    want(FILL_BYTE);
  endtask

  // Offer six bytes to the read buffer; four must be taken
  task automatic fill();
    n = 0;
    dq.delete();
    repeat (6)
    begin
      rd_data = 8'($random(seed));
      rd_valid = 1'b1;
      @(posedge clock);
      if (rd_ready === 1'b1)
      begin
        dq.push_back(rd_data);
        n++;
      end
      #1;
    end
    rd_valid = 1'b0;
    check(16'(n), 16'h0004);
  endtask

  // Cut a hang short
  initial
  begin
    #300000;
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end

  // Main sequence
  initial
  begin
    seed = 28796;
    clock = 1'b0;
    {rstn, ev, rq, idl, card_locked, card_busy, multi_write} = '0;
    {reg_req, reg_sel, rd_valid, rd_data} = '0;
    err_count = 0;
    check_count = 0;
    tick(6);
    rstn = 1'b1;
    tick();
    check(16'(flags), 16'h0000);
    check(16'(idle_state), 16'h0001);
    check(16'(so_oe), 16'h0000);
    host_u.select();
    tick();
    $display("reset test done");
    // Short response: address and checksum errors, idle still set
    pulse(15'h000A, 4'h0);
    check(16'(flags), 16'h000A);
    ask(4'h1);
    want(8'h29);
    frame(2);
    check(16'(flags), 16'h000A);
    frame(1);
    check(16'(flags), 16'h0000);
    pulse('0, 4'h0, 2'h1);
    check(16'(idle_state), 16'h0000);
    pulse('0, 4'h0, 2'h2);
    ask(4'h1);
    want(8'h01);
    frame(3);
    check(16'(idle_state), 16'h0001);
    pulse('0, 4'h0, 2'h1);
    $display("short response test done");
    // Every flag alone, read back through the two-byte status
    for (int i = 0; i < NFLAG; i++)
    begin
      pulse(15'h0001 << i, 4'h0);
      check(16'(flags), 16'(15'h0001 << i));
      ask(4'h2);
      want(STAT_OF[i][15:8]);
      want(STAT_OF[i][7:0]);
      frame(5);
      check(16'(flags), 16'h0000);
    end
    $display("status test done");
    // Error token clears only what it carries
    pulse(15'h4E40, 4'h0);
    ask(4'h4);
    want(8'h0F);
    frame(3);
    check(16'(flags), 16'h4000);
    card_locked = 1'b1;
    ask(4'h2);
    want(8'h00);
    want(8'h81);
    frame(4);
    check(16'(flags), 16'h0000);
    card_locked = 1'b0;
    $display("error token test done");
    // Busy after response, deselect and reselect
    card_busy = 1'b1;
    ask(4'h1);
    want(8'h00);
    want(BUSY_BYTE);
    frame(4);
    host_u.deselect();
    tick(4);
    check(16'(so_oe), 16'h0000);
    host_u.select();
    tick();
    want(BUSY_BYTE);
    frame(1);
    card_busy = 1'b0;
    want(8'h00, 8'h00);
    want(8'hFF);
    frame(2);
    check(16'(oe_max <= 4), 16'h0001);
    $display("busy test done");
    // Drain a full buffer with the host stalling
    fill();
    want(FILL_BYTE);
    foreach (dq[k]) want(dq[k]);
    want(FILL_BYTE);
    frame(6);
    // Stop in the middle of read data
    fill();
    pulse(15'h0001, 4'h0);
    want(FILL_BYTE);
    want(dq[0]);
    want(dq[1]);
    frame(3);
    pulse('0, 4'h8);
    n = 0;
    for (int k = 0; k < 10 && n == 0; k++)
    begin
      host_u.xfer(FILL_BYTE);
      tick(10);
      n = (k > 0 && host_rx === 8'h40) ? 1 : 0;
    end
    check(16'(n), 16'h0001);
    host_u.xfer(FILL_BYTE);
    tick(10);
    check(16'(host_rx), 16'h00FF);
    check(16'(flags), 16'h0000);
    $display("read stop test done");
    // Stop token ending a multi-block write
    multi_write = 1'b1;
    card_busy = 1'b1;
    host_u.xfer(STOP_TRAN_TOKEN);
    tick(10);
    check(16'(last_rx), 16'(STOP_TRAN_TOKEN));
    want(8'h00, 8'h00);
    want(BUSY_BYTE);
    frame(2);
    multi_write = 1'b0;
    card_busy = 1'b0;
    frame(1);
    $display("write stop test done");
    // Register access: three selects legal, the fourth refused
    for (int s = 0; s < 4; s++)
    begin
      reg_sel = 2'(s);
      reg_req = 1'b1;
      tick();
      reg_req = 1'b0;
      check(16'(reg_ok), 16'(s < 3));
      tick(2);
      check(16'(flags[F_ILL]), 16'(s == 3));
    end
    ask(4'h1);
    want(8'h04);
    frame(3);
    check(16'(flags), 16'h0000);
    $display("register test done");
    results();
  end
endmodule
